/* File: design/lble_evaluator.sv */
// single-bit ladder logic evaluator with result stack and edge triggers
module lble_evaluator
(
    input  wire logic                       clk_in,
    input  wire logic                       sys_rst_in,
    input  wire logic                       exec_in,
    input  wire logic [lble_pkg::OP_W-1:0]  op_in,
    input  wire logic [1:0]                 mode_in,
    input  wire logic                       operand_bit_in,
    input  wire logic                       operand_direct_in,
    input  wire logic [lble_pkg::TRIG_W-1:0] trig_slot_in,
    input  wire logic                       restart_in,
    output logic                            acc_out,
    output logic                            coil_we_out,
    output logic                            coil_bit_out,
    output logic [2:0]                      steps_out,
    output logic                            halted_out,
    output logic                            operand_fault_out,
    output logic                            stack_err_out,
    output logic                            ready_out
);
    logic                               acc;
    logic                               next_acc;
    logic [lble_pkg::STACK_D-1:0]       stack_mem;
    logic [lble_pkg::SP_W-1:0]          sp;
    logic [lble_pkg::TRIG_SLOTS-1:0]    trig_prev;
    logic                               push;
    logic                               pop;
    logic                               top;
    logic                               go;
    logic                               refuse;
    lble_pkg::lble_op_t                 op;
    lble_pkg::lble_state_t              state;

    // contact state: closed contacts conduct when the bit is off
    function automatic logic contact(input logic bit_v, input logic closed);
        contact = closed ? ~bit_v : bit_v; // RULE7
    endfunction

    assign op     = lble_pkg::lble_op_t'(op_in);
    assign ready_out = (state == lble_pkg::LBLE_RUN);
    assign go     = exec_in && ready_out;
    assign refuse = (op == lble_pkg::LBLE_WRISE_LOAD || op == lble_pkg::LBLE_WRISE_COMB)
                    && operand_direct_in; // RULE11
    assign top    = (sp == '0) ? 1'b0 : stack_mem[sp[4:0] - 5'h1];
    assign push   = go && !refuse && (op == lble_pkg::LBLE_LOAD_OPEN
                    || op == lble_pkg::LBLE_LOAD_CLOSE
                    || op == lble_pkg::LBLE_WRISE_LOAD); // RULE1 RULE4
    assign pop    = go && (op == lble_pkg::LBLE_JOIN_SER
                    || op == lble_pkg::LBLE_JOIN_PAR); // RULE17

    // rising edge of the operand bit for the word detect forms
    logic wrise;
    assign wrise = operand_bit_in && !trig_prev[trig_slot_in];

    always_comb
    begin
        next_acc = acc;
        unique case (op)
            lble_pkg::LBLE_LOAD_OPEN:  next_acc = contact(operand_bit_in, 1'b0); // RULE1
            lble_pkg::LBLE_SER_OPEN:   next_acc = acc & contact(operand_bit_in, 1'b0); // RULE2
            lble_pkg::LBLE_PAR_OPEN:   next_acc = acc | contact(operand_bit_in, 1'b0); // RULE3
            lble_pkg::LBLE_LOAD_CLOSE: next_acc = contact(operand_bit_in, 1'b1); // RULE4
            lble_pkg::LBLE_SER_CLOSE:  next_acc = acc & contact(operand_bit_in, 1'b1); // RULE5
            lble_pkg::LBLE_PAR_CLOSE:  next_acc = acc | contact(operand_bit_in, 1'b1); // RULE6
            lble_pkg::LBLE_JOIN_SER:   next_acc = top & acc; // RULE8
            lble_pkg::LBLE_JOIN_PAR:   next_acc = top | acc; // RULE9
            lble_pkg::LBLE_COMPLEMENT: next_acc = ~acc; // RULE12
            lble_pkg::LBLE_RISE_TRIG:  next_acc = acc && !trig_prev[trig_slot_in]; // RULE13
            lble_pkg::LBLE_FALL_TRIG:  next_acc = !acc && trig_prev[trig_slot_in]; // RULE14
            lble_pkg::LBLE_WRISE_LOAD: next_acc = wrise; // RULE11
            lble_pkg::LBLE_WRISE_COMB:
            begin
                if (mode_in == lble_pkg::WRISE_PAR)
                    next_acc = acc | wrise;
                else
                    next_acc = acc & wrise;
            end
            default:                   next_acc = acc;
        endcase
    end

    // accumulator updated in the same execution cycle
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            acc <= 1'b0;
        else if (go && !refuse)
            acc <= next_acc; // RULE18
    end

    // result stack, newest entry at sp-1
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            sp        <= '0;
            stack_mem <= '0;
        end
        else if (push && sp != lble_pkg::SP_W'(lble_pkg::STACK_D))
        begin
            stack_mem[sp[4:0]] <= acc; // RULE1 RULE4
            sp                 <= sp + 6'h1;
        end
        else if (pop && sp != '0)
            sp <= sp - 6'h1; // RULE17
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            stack_err_out <= 1'b0;
        else if (push && sp == lble_pkg::SP_W'(lble_pkg::STACK_D))
            stack_err_out <= 1'b1;
        else if (pop && sp == '0)
            stack_err_out <= 1'b1;
        else if (restart_in)
            stack_err_out <= 1'b0;
    end

    // previous-scan values per trigger slot
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            trig_prev <= '0;
        else if (go && (op == lble_pkg::LBLE_RISE_TRIG || op == lble_pkg::LBLE_FALL_TRIG))
            trig_prev[trig_slot_in] <= acc; // RULE13 RULE14
        else if (go && !refuse && (op == lble_pkg::LBLE_WRISE_LOAD
                 || op == lble_pkg::LBLE_WRISE_COMB))
            trig_prev[trig_slot_in] <= operand_bit_in; // RULE11
    end

    // coil write strobe and step count of the executed instruction
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            coil_we_out  <= 1'b0;
            coil_bit_out <= 1'b0;
            steps_out    <= 3'h0;
        end
        else
        begin
            coil_we_out <= go && (op == lble_pkg::LBLE_COIL); // RULE16
            if (go && op == lble_pkg::LBLE_COIL)
                coil_bit_out <= acc; // RULE16
            if (go)
                steps_out <= (op == lble_pkg::LBLE_WRISE_LOAD || op == lble_pkg::LBLE_WRISE_COMB)
                             ? lble_pkg::STEPS_WRISE : lble_pkg::STEPS_ONE; // RULE10 RULE11 RULE12
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            operand_fault_out <= 1'b0;
        else if (go && refuse)
            operand_fault_out <= 1'b1; // RULE11
        else if (restart_in)
            operand_fault_out <= 1'b0;
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            state <= lble_pkg::LBLE_RUN;
        else
        begin
            unique case (state)
                lble_pkg::LBLE_RUN:
                begin
                    if (go && op == lble_pkg::LBLE_HALT)
                        state <= lble_pkg::LBLE_HALTED; // RULE15
                    else if (go && refuse)
                        state <= lble_pkg::LBLE_FAULTED; // RULE11
                end
                lble_pkg::LBLE_HALTED,
                lble_pkg::LBLE_FAULTED:
                begin
                    if (restart_in)
                        state <= lble_pkg::LBLE_RUN;
                end
                default: state <= lble_pkg::LBLE_RUN;
            endcase
        end
    end

    assign acc_out    = acc;
    assign halted_out = (state == lble_pkg::LBLE_HALTED);
endmodule

/* File: design/lble_pkg.sv */
// constants and types for the ladder bit logic evaluator
// Notes on behaviour
// RULE1: open-contact load pushes accumulator, then loads operand bit.
// RULE2: series open contact ANDs operand bit into accumulator.
// RULE3: parallel open contact ORs operand bit into accumulator.
// RULE4: closed-contact load pushes accumulator, then loads contact state.
// RULE5: series closed contact ANDs contact state into accumulator.
// RULE6: parallel closed contact ORs contact state into accumulator.
// RULE7: closed contact state is the complement of the stored bit.
// RULE8: series block join ANDs top of stack into accumulator.
// RULE9: parallel block join ORs top of stack into accumulator.
// RULE10: block joins take no operand and one program step.
// RULE11: word rise detects take five steps and refuse direct-input operands.
// RULE12: complement instruction inverts accumulator in one step.
// RULE13: rising trigger passes true only on a false-to-true change.
// RULE14: falling trigger passes true only on a true-to-false change.
// RULE15: halt instruction stops further program execution.
// RULE16: coil drive writes accumulator into the destination bit.
// RULE17: reserved results are last-in first-out; joins pop the newest.
// RULE18: each contact finishes read, combine and update in one execution.
package lble_pkg;
    localparam int OP_W       = 4;
    localparam int ADDR_W     = 16;
    localparam int STACK_D    = 32;
    localparam int SP_W       = 6;
    localparam int TRIG_SLOTS = 16;
    localparam int TRIG_W     = 4;

    typedef enum logic [OP_W-1:0] {
        LBLE_NOP        = 4'h0,
        LBLE_LOAD_OPEN  = 4'h1,
        LBLE_SER_OPEN   = 4'h2,
        LBLE_PAR_OPEN   = 4'h3,
        LBLE_LOAD_CLOSE = 4'h4,
        LBLE_SER_CLOSE  = 4'h5,
        LBLE_PAR_CLOSE  = 4'h6,
        LBLE_JOIN_SER   = 4'h7,
        LBLE_JOIN_PAR   = 4'h8,
        LBLE_COMPLEMENT = 4'h9,
        LBLE_RISE_TRIG  = 4'ha,
        LBLE_FALL_TRIG  = 4'hb,
        LBLE_HALT       = 4'hc,
        LBLE_COIL       = 4'hd,
        LBLE_WRISE_LOAD = 4'he,
        LBLE_WRISE_COMB = 4'hf
    } lble_op_t;

    // word rise combine mode carried on mode_in
    localparam logic [1:0] WRISE_SER = 2'h1;
    localparam logic [1:0] WRISE_PAR = 2'h2;

    localparam logic [2:0] STEPS_ONE   = 3'h1;
    localparam logic [2:0] STEPS_WRISE = 3'h5;

    typedef enum logic [2:0] {
        LBLE_RUN     = 3'b001,
        LBLE_HALTED  = 3'b010,
        LBLE_FAULTED = 3'b100
    } lble_state_t;
endpackage

/* File: verif/lble_bit_mem.sv */
// device bit memory model, read without wait
module lble_bit_mem
#(
    parameter logic [15:0] INIT = 16'h0
)
(
    input  wire logic [3:0] addr_in,
    output logic            bit_out
);
    timeunit 1ns;
    timeprecision 1ps;
    assign bit_out = INIT[addr_in];
endmodule

/* File: verif/lble_properties.sv */
// port-level assertions for the evaluator
module lble_properties
(
    input wire logic                      clk_in,
    input wire logic                      sys_rst_in,
    input wire logic                      exec_in,
    input wire logic [lble_pkg::OP_W-1:0] op_in,
    input wire logic                      operand_bit_in,
    input wire logic                      operand_direct_in,
    input wire logic                      acc_out,
    input wire logic                      coil_we_out,
    input wire logic                      coil_bit_out,
    input wire logic                      ready_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    logic go;
    assign go = exec_in && ready_out;
    a_load_open: assert property (go && op_in == 4'h1 |=> acc_out == $past(operand_bit_in))
        else $error("open load wrong");
    a_load_closed: assert property (go && op_in == 4'h4 ##1 1'b1 |-> acc_out != $past(operand_bit_in))
        else $error("closed load wrong");
    a_series_open: assert property (go && op_in == 4'h2 |=>
        acc_out == ($past(acc_out) & $past(operand_bit_in))) else $error("series open wrong");
    a_par_open: assert property (go && op_in == 4'h3 |=>
        acc_out == ($past(acc_out) | $past(operand_bit_in))) else $error("parallel open wrong");
    a_series_closed: assert property (go && op_in == 4'h5 |=>
        acc_out == ($past(acc_out) & !$past(operand_bit_in))) else $error("series closed wrong");
    a_par_closed: assert property (go && op_in == 4'h6 |=>
        acc_out == ($past(acc_out) | !$past(operand_bit_in))) else $error("par closed wrong");
    a_coil_drive: assert property (go && op_in == 4'hd |=>
        coil_we_out && coil_bit_out == $past(acc_out)) else $error("coil drive wrong");
    a_direct_refused: assert property (go && op_in inside {4'he, 4'hf} && operand_direct_in
        |=> $stable(acc_out) && !ready_out) else $error("direct operand taken");
    c_coil: cover property (go && op_in == 4'hd);
    c_join: cover property (go && op_in == 4'h8);
    c_refuse: cover property (go && op_in == 4'he && operand_direct_in);
endmodule
bind lble_evaluator lble_properties u_lble_properties (.*);

/* File: verif/testbench.sv */
// self-checking bench for the evaluator
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] MEM_INIT = 16'h5a3c;
    logic       clk_in = 1'b0;
    logic       sys_rst_in = 1'b1;
    logic       exec_in = 1'b0;
    logic [3:0] op_in = 4'h0;
    logic [1:0] mode_in = 2'h0;
    logic [3:0] addr = 4'h0;
    logic       operand_bit_in;
    logic       operand_direct_in = 1'b0;
    logic [3:0] trig_slot_in = 4'h0;
    logic       restart_in = 1'b0;
    logic       acc_out, coil_we_out, coil_bit_out, halted_out;
    logic       operand_fault_out, stack_err_out, ready_out;
    logic [2:0] steps_out;
    logic       acc = 1'b0;
    logic       stk[$];
    logic [15:0] slot = 16'h0;
    logic [3:0] ops[12] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hd};
    int         failures = 0;
    int         n_tests = 0;
    always #5 clk_in = ~clk_in;
    lble_evaluator u_lble_evaluator (.*);
    lble_bit_mem #(.INIT(MEM_INIT)) u_lble_bit_mem (.addr_in(addr), .bit_out(operand_bit_in));
    task automatic chk(string name, logic [4:0] got, logic [4:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // model: loads push the old result, joins pop the newest or 0 if empty
    function automatic void predict(logic [3:0] op, logic [3:0] a, logic [3:0] s);
        logic nb;
        logic top;
        nb = MEM_INIT[a] ^ (op inside {4'h4, 4'h5, 4'h6});
        top = 1'b0;
        if (op inside {4'h1, 4'h4})
            stk.push_back(acc);
        if (op inside {4'h7, 4'h8} && stk.size() > 0)
            top = stk.pop_back();
        case (op)
            4'h1, 4'h4: acc = nb;
            4'h2, 4'h5: acc = acc & nb;
            4'h3, 4'h6: acc = acc | nb;
            4'h7: acc = acc & top;
            4'h8: acc = acc | top;
            4'h9: acc = ~acc;
            4'ha: {acc, slot[s]} = {acc & ~slot[s], acc};
            4'hb: {acc, slot[s]} = {~acc & slot[s], acc};
            default: ;
        endcase
    endfunction
    // caller sits on a falling edge; returns one cycle later
    task automatic run(logic [3:0] op, logic [3:0] a, logic [3:0] s, logic d);
        exec_in <= 1'b1;
        op_in <= op;
        addr <= a;
        trig_slot_in <= s;
        operand_direct_in <= d;
        @(negedge clk_in);
    endtask
    task automatic step(logic [3:0] op, logic [3:0] a, logic [3:0] s);
        run(op, a, s, 1'b0);
        predict(op, a, s);
        chk("acc", acc_out, acc);
    endtask
    task automatic rearm();
        exec_in <= 1'b0;
        restart_in <= 1'b1;
        @(negedge clk_in);
        restart_in <= 1'b0;
        @(negedge clk_in);
        chk("rearm", {ready_out, operand_fault_out}, 2'b10);
    endtask
    initial
    begin
        logic [3:0] op;
        logic       old;
        void'($urandom(32'hec36007a));
        repeat (5) @(negedge clk_in);
        sys_rst_in <= 1'b0;
        chk("reset", {ready_out, acc_out, coil_we_out}, 3'b100);
        repeat (400)
        begin
            op = ops[$urandom_range(11)];
            // keep well inside the 32-entry stack
            if (stk.size() > 28)
                op = 4'h8;
            old = acc;
            step(op, 4'($urandom_range(15)), 4'($urandom_range(3)));
            chk("steps", steps_out, 3'h1);
            chk("coil", {coil_we_out, coil_bit_out & coil_we_out}, {op == 4'hd, old & (op == 4'hd)});
        end
        while (stk.size() > 0)
            step(4'h8, 4'h0, 4'h0);
        step(4'h7, 4'h0, 4'h0);
        chk("stack_err", stack_err_out, 1'b1);
        step(4'h1, 4'h2, 4'h0);
        run(4'he, 4'h0, 4'h0, 1'b1);
        chk("fault", {operand_fault_out, ready_out, acc_out}, {2'b10, acc});
        rearm();
        step(4'h4, 4'h0, 4'h0);
        run(4'hc, 4'h0, 4'h0, 1'b0);
        chk("halt", {halted_out, ready_out, steps_out}, {2'b10, 3'h1});
        run(4'h9, 4'h0, 4'h0, 1'b0);
        chk("held", acc_out, acc);
        rearm();
        mode_in <= 2'h2;
        run(4'hf, 4'h2, 4'h5, 1'b0);
        chk("steps", {operand_fault_out, steps_out}, 4'h5);
        chk("wrise_par", acc_out, 1'b1);
        mode_in <= 2'h1;
        run(4'hf, 4'h2, 4'h5, 1'b0);
        chk("wrise_ser", acc_out, 1'b0);
        run(4'he, 4'h2, 4'h6, 1'b0);
        chk("wrise_load", {acc_out, steps_out}, 4'hd);
        exec_in <= 1'b0;
        end_sim();
    end
    initial
    begin
        repeat (3000) @(posedge clk_in);
        failures++;
        end_sim();
    end
endmodule
